// ===== hdl/gfam_top.v
// Functional notes
// RULE1: pin functions take effect only once the reset sequence is done.
// RULE2: sixteen pins, numbered zero to fifteen, each with its own configuration.
// RULE3: any pin may take any function aimed at any source.
// RULE4: input mode samples the pin into a readable register; input is default.
// RULE5: output mode drives the pin from a host-written register bit.
// RULE6: pins configured alike show identical outputs.
// RULE7: loss-of-signal mode shows the selected monitor alarm, optionally inverted.
// RULE8: loss-of-signal output follows the alarm live, never latched.
// RULE9: live loss-of-lock mode drives high while selected loop is unlocked.
// RULE10: sticky loss-of-lock latches on any lock change, either direction.
// RULE11: an option inverts the sticky loss-of-lock output.
// RULE12: latched status holds until the host writes the clear register.
// RULE13: holdover mode shows the selected channel's holdover status.
// RULE14: single-ended mode copies the clock to both pads, complement invertible.
// RULE15: two-bit swing field selects one of four nominal swings.
// RULE16: three-bit crossing field selects one of eight common mode levels.
// RULE17: holdover sticky mode latches on holdover entry or exit, invertible, clearable.
// RULE18: pin inputs pass a two-stage synchronizer before any use.
`timescale 1ns/1ps
`default_nettype none
`include "gfam_defines.vh"
module gfam_top (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // device status
   input  wire        init_done,
   input  wire [3:0]  ref_los_alarm,
   input  wire [4:0]  pll_locked,
   input  wire [3:0]  pll_holdover,
   // gpio pins
   input  wire [15:0] gpio_in,
   output reg  [15:0] gpio_out,
   output reg  [15:0] gpio_oe,
   // output buffer
   input  wire        buf_clk_src,
   output reg         true_output_pad,
   output reg         complement_output_pad,
   output reg  [1:0]  diff_swing_select,
   output reg  [2:0]  crossing_level_select
);
   // ****************************************
   // decode helpers
   // ****************************************
   function is_cfg_addr;
      input [11:0] a;
      begin
         is_cfg_addr = (a <= `GFAM_ADDR_CFG_LAST);
      end
   endfunction

   // alarm level of one pin before inversion; unknown selects read as zero
   function pin_alarm;
      input [2:0] mode;
      input [2:0] sel;
      input [3:0] los;
      input [4:0] lock;
      input [4:0] lol_stk;
      input [3:0] ho;
      input [3:0] ho_stk;
      reg         idx_ok;
      reg         ref_ok;
      begin
         idx_ok = (sel <= 3'h4);
         ref_ok = (sel <= 3'h3);
         pin_alarm = 1'b0;
         case (mode)
            `GFAM_MODE_LOS:        pin_alarm = ref_ok & los[sel[1:0]];
            `GFAM_MODE_LOL_LIVE:   pin_alarm = idx_ok & ~lock[sel];
            `GFAM_MODE_LOL_STICKY: pin_alarm = idx_ok & lol_stk[sel];
            `GFAM_MODE_HO_LIVE:    pin_alarm = ref_ok & ho[sel[1:0]];
            `GFAM_MODE_HO_STICKY:  pin_alarm = ref_ok & ho_stk[sel[1:0]];
            default:               pin_alarm = 1'b0;
         endcase
      end
   endfunction

   function is_drive_mode;
      input [2:0] mode;
      begin
         is_drive_mode = (mode != `GFAM_MODE_INPUT) && (mode <= `GFAM_MODE_HO_STICKY);
      end
   endfunction

   // ****************************************
   // pin input synchronizer
   // ****************************************
   reg [15:0] in_meta_q;
   reg [15:0] in_sync_q;

   // RULE18: two flop sync
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_meta_q <= 16'h0000;
         in_sync_q <= 16'h0000;
      end else begin
         in_meta_q <= gpio_in;
         in_sync_q <= in_meta_q;
      end
   end

   // ****************************************
   // write channel
   // ****************************************
   reg  [11:0]  aw_addr_q;
   reg          aw_have_q;
   reg  [31:0]  w_data_q;
   reg  [3:0]   w_strb_q;
   reg          w_have_q;
   reg  [7:0]   buf_cfg_q;
   wire         do_write;
   wire         wr_cfg;
   wire         wr_clr;
   wire [255:0] cfg_flat;
   wire [15:0]  mem_rd_data;

   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_cfg   = do_write && is_cfg_addr(aw_addr_q);
   assign wr_clr   = do_write && (aw_addr_q == `GFAM_ADDR_STICKY_CLR);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q     <= 12'h000;
         aw_have_q     <= 1'b0;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `GFAM_RESP_OKAY;
         buf_cfg_q     <= `GFAM_BUF_RESET;
      end else begin
         // each channel is taken on its own, in either order
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         if (do_write) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (is_cfg_addr(aw_addr_q) || (aw_addr_q == `GFAM_ADDR_STICKY_CLR)) begin
               s_axi_bresp <= `GFAM_RESP_OKAY;
            end else if (aw_addr_q == `GFAM_ADDR_BUF_CFG) begin
               s_axi_bresp <= `GFAM_RESP_OKAY;
               if (w_strb_q[0]) begin
                  buf_cfg_q <= w_data_q[7:0];
               end
            end else if ((aw_addr_q == `GFAM_ADDR_INPUTS) ||
                         (aw_addr_q == `GFAM_ADDR_STICKY) ||
                         (aw_addr_q == `GFAM_ADDR_LIVE)) begin
               // read-only registers ignore the data
               s_axi_bresp <= `GFAM_RESP_OKAY;
            end else begin
               s_axi_bresp <= `GFAM_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // configuration store
   // ****************************************
   reg  [3:0] rd_idx_d;
   // RULE2: sixteen config words
   gfam_cfg_mem u_cfg_mem (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .wr_en     (wr_cfg),
      .wr_idx    (aw_addr_q[5:2]),
      .wr_data   (w_data_q[15:0]),
      .wr_strb   (w_strb_q[1:0]),
      .rd_idx    (rd_idx_d),
      .rd_data_q (mem_rd_data),
      .cfg_flat  (cfg_flat)
   );

   // ****************************************
   // sticky status
   // ****************************************
   reg  [4:0] lock_prev_q;
   reg  [3:0] ho_prev_q;
   reg        primed_q;
   reg  [4:0] lol_stk_q;
   reg  [3:0] ho_stk_q;
   wire [4:0] lol_clr;
   wire [3:0] ho_clr;

   assign lol_clr = (wr_clr && w_strb_q[0]) ? w_data_q[`GFAM_STK_LOL_LSB +: 5] : 5'h00;
   assign ho_clr  = (wr_clr && w_strb_q[1]) ? w_data_q[`GFAM_STK_HO_LSB +: 4] : 4'h0;

   always @(posedge aclk) begin
      if (!aresetn) begin
         lock_prev_q <= 5'h00;
         ho_prev_q   <= 4'h0;
         primed_q    <= 1'b0;
         lol_stk_q   <= 5'h00;
         ho_stk_q    <= 4'h0;
      end else begin
         lock_prev_q <= pll_locked;
         ho_prev_q   <= pll_holdover;
         // no edge is seen until a first sample is held
         primed_q    <= 1'b1;
         // RULE10: any lock change latches; RULE12: clear on write, set wins
         lol_stk_q   <= (lol_stk_q & ~lol_clr) |
                        ({5{primed_q}} & (pll_locked ^ lock_prev_q));
         // RULE17: holdover entry or exit latches, cleared like the others
         ho_stk_q    <= (ho_stk_q & ~ho_clr) |
                        ({4{primed_q}} & (pll_holdover ^ ho_prev_q));
      end
   end

   // ****************************************
   // pin function
   // ****************************************
   reg [15:0] pin_out_d;
   reg [15:0] pin_oe_d;
   reg [15:0] pin_cfg;
   integer    p;

   // RULE3: any pin, any function; RULE6: same config gives same output
   always @* begin
      pin_out_d = 16'h0000;
      pin_oe_d  = 16'h0000;
      pin_cfg   = 16'h0000;
      for (p = 0; p < 16; p = p + 1) begin
         pin_cfg = cfg_flat[16*p +: 16];
         if (pin_cfg[`GFAM_CFG_MODE_LSB +: 3] == `GFAM_MODE_OUTPUT) begin
            // RULE5: drive from register
            pin_out_d[p] = pin_cfg[`GFAM_CFG_LVL_BIT];
         end else begin
            // RULE7: los with inversion; RULE8: live level; RULE9: live unlock
            // RULE11: invert sticky lock; RULE13: holdover status
            pin_out_d[p] = pin_alarm(pin_cfg[`GFAM_CFG_MODE_LSB +: 3],
                                     pin_cfg[`GFAM_CFG_SEL_LSB +: 3],
                                     ref_los_alarm, pll_locked, lol_stk_q,
                                     pll_holdover, ho_stk_q) ^
                           pin_cfg[`GFAM_CFG_INV_BIT];
         end
         // RULE1: no drive before reset sequence ends
         pin_oe_d[p] = init_done && is_drive_mode(pin_cfg[`GFAM_CFG_MODE_LSB +: 3]);
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         gpio_out <= 16'h0000;
         gpio_oe  <= 16'h0000;
      end else begin
         gpio_out <= pin_out_d & pin_oe_d;
         gpio_oe  <= pin_oe_d;
      end
   end

   // ****************************************
   // output buffer
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         true_output_pad       <= 1'b0;
         complement_output_pad <= 1'b0;
         diff_swing_select     <= 2'h0;
         crossing_level_select <= 3'h0;
      end else begin
         // RULE14: both pads copy the clock
         true_output_pad       <= buf_clk_src;
         complement_output_pad <= buf_clk_src ^ buf_cfg_q[`GFAM_BUF_CINV_BIT];
         // RULE15: swing code to pad
         diff_swing_select     <= buf_cfg_q[`GFAM_BUF_SWING_LSB +: 2];
         // RULE16: crossing code to pad
         crossing_level_select <= buf_cfg_q[`GFAM_BUF_CROSS_LSB +: 3];
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   reg [11:0] ar_addr_q;
   reg        rd_pend_q;

   always @* begin
      rd_idx_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr[5:2] : ar_addr_q[5:2];
   end

   // the store answers one cycle late, so a read takes two cycles
   always @(posedge aclk) begin
      if (!aresetn) begin
         ar_addr_q     <= 12'h000;
         rd_pend_q     <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `GFAM_RESP_OKAY;
      end else begin
         s_axi_arready <= !rd_pend_q && !s_axi_rvalid &&
                          !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            ar_addr_q <= s_axi_araddr;
            rd_pend_q <= 1'b1;
         end
         if (rd_pend_q) begin
            rd_pend_q    <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `GFAM_RESP_OKAY;
            if (is_cfg_addr(ar_addr_q)) begin
               s_axi_rdata <= {16'h0000, mem_rd_data};
            end else if (ar_addr_q == `GFAM_ADDR_INPUTS) begin
               // RULE4: synchronized pin levels
               s_axi_rdata <= {16'h0000, in_sync_q};
            end else if (ar_addr_q == `GFAM_ADDR_STICKY) begin
               s_axi_rdata <= {20'h00000, ho_stk_q, 3'h0, lol_stk_q};
            end else if (ar_addr_q == `GFAM_ADDR_STICKY_CLR) begin
               s_axi_rdata <= 32'h00000000;
            end else if (ar_addr_q == `GFAM_ADDR_BUF_CFG) begin
               s_axi_rdata <= {24'h000000, buf_cfg_q};
            end else if (ar_addr_q == `GFAM_ADDR_LIVE) begin
               s_axi_rdata <= {19'h00000, pll_holdover, pll_locked, ref_los_alarm};
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `GFAM_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== shared/gfam_defines.vh
`ifndef GFAM_DEFINES_VH
`define GFAM_DEFINES_VH
// ****************************************
// register byte addresses
// ****************************************
`define GFAM_ADDR_CFG_LAST    12'h03c
`define GFAM_ADDR_INPUTS      12'h040
`define GFAM_ADDR_STICKY      12'h044
`define GFAM_ADDR_STICKY_CLR  12'h048
`define GFAM_ADDR_BUF_CFG     12'h04c
`define GFAM_ADDR_LIVE        12'h050
// ****************************************
// pin configuration word fields
// ****************************************
`define GFAM_CFG_W            16
`define GFAM_CFG_MODE_LSB     0
`define GFAM_CFG_SEL_LSB      4
`define GFAM_CFG_INV_BIT      8
`define GFAM_CFG_LVL_BIT      12
`define GFAM_CFG_RESET        16'h0000
// ****************************************
// pin modes
// ****************************************
`define GFAM_MODE_INPUT       3'h0
`define GFAM_MODE_OUTPUT      3'h1
`define GFAM_MODE_LOS         3'h2
`define GFAM_MODE_LOL_LIVE    3'h3
`define GFAM_MODE_LOL_STICKY  3'h4
`define GFAM_MODE_HO_LIVE     3'h5
`define GFAM_MODE_HO_STICKY   3'h6
// ****************************************
// sticky register and buffer fields
// ****************************************
`define GFAM_STK_LOL_LSB      0
`define GFAM_STK_HO_LSB       8
`define GFAM_BUF_SWING_LSB    0
`define GFAM_BUF_CROSS_LSB    2
`define GFAM_BUF_CINV_BIT     5
`define GFAM_BUF_RESET        8'h00
// ****************************************
// bus responses
// ****************************************
`define GFAM_RESP_OKAY        2'h0
`define GFAM_RESP_SLVERR      2'h2
`endif

// ===== hdl/gfam_cfg_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "gfam_defines.vh"
// ****************************************
// sixteen pin configuration words
// ****************************************
module gfam_cfg_mem (
   // clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // write port
   input  wire         wr_en,
   input  wire [3:0]   wr_idx,
   input  wire [15:0]  wr_data,
   input  wire [1:0]   wr_strb,
   // read port
   input  wire [3:0]   rd_idx,
   output reg  [15:0]  rd_data_q,
   // all words in parallel for the pin logic
   output wire [255:0] cfg_flat
);
   reg [15:0] mem_q [0:15];
   integer    k;
   genvar     g;

   always @(posedge aclk) begin
      if (!aresetn) begin
         for (k = 0; k < 16; k = k + 1) begin
            mem_q[k] <= `GFAM_CFG_RESET;
         end
         rd_data_q <= 16'h0000;
      end else begin
         if (wr_en && wr_strb[0]) begin
            mem_q[wr_idx][7:0] <= wr_data[7:0];
         end
         if (wr_en && wr_strb[1]) begin
            mem_q[wr_idx][15:8] <= wr_data[15:8];
         end
         rd_data_q <= mem_q[rd_idx];
      end
   end

   generate
      for (g = 0; g < 16; g = g + 1) begin : flat
         assign cfg_flat[16*g +: 16] = mem_q[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ===== dv/gfam_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker for the pin block
// ****************************************
module gfam_properties (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // pins and pads
   input wire logic        init_done,
   input wire logic [15:0] gpio_out,
   input wire logic [15:0] gpio_oe,
   input wire logic        buf_clk_src,
   input wire logic        true_output_pad
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_NO_DRIVE: assert property (!init_done |=> gpio_oe == 16'h0000)
      else $error("pin driven before init done");
   AST_OUT_MASK: assert property ((gpio_out & ~gpio_oe) == 16'h0000)
      else $error("released pin shows a level");
   AST_PAD_COPY: assert property ($past(aresetn) && $past(aresetn, 2)
      |-> true_output_pad == $past(buf_clk_src)) else $error("pad not a copy of clock");
   AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   AST_WR_REFUSE: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("wready high after handshake");
   AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid held after taken");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read answer late");
   AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid held after taken");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule
bind gfam_top gfam_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .init_done, .gpio_out, .gpio_oe,
   .buf_clk_src, .true_output_pad);
`default_nettype wire

// ===== dv/gfam_board.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// board side of the pins
// ****************************************
module gfam_board (
   // pins from the block
   input  wire logic [15:0] gpio_out,
   input  wire logic [15:0] gpio_oe,
   // level the far parts drive on released pins
   input  wire logic [15:0] far_level,
   // resolved pin level
   output wire logic [15:0] gpio_in
);
   // a driving pin wins; far parts only drive pins the block has released
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & far_level);
endmodule
`default_nettype wire

// ===== dv/gpio_function_alarm_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gfam_defines.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module gpio_function_alarm_mux_tb;
   // ****************************************
   // stimulus and wiring
   // ****************************************
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   logic        init_done = 1'b0;
   logic [3:0]  ref_los_alarm = 4'h0;
   logic [4:0]  pll_locked = 5'h1f;
   logic [3:0]  pll_holdover = 4'h0;
   logic [15:0] far_level = 16'h5a3c;
   wire  [15:0] gpio_in, gpio_out, gpio_oe;
   logic        buf_clk_src = 1'b0;
   wire         true_output_pad, complement_output_pad;
   wire  [1:0]  diff_swing_select;
   wire  [2:0]  crossing_level_select;
   int          bad_count = 0;
   int          n_checks = 0;
   logic        inv;

   always #5 aclk = ~aclk;
   always @(posedge aclk) buf_clk_src <= ~buf_clk_src;

   gfam_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .init_done,
      .ref_los_alarm, .pll_locked, .pll_holdover, .gpio_in, .gpio_out, .gpio_oe,
      .buf_clk_src, .true_output_pad, .complement_output_pad, .diff_swing_select,
      .crossing_level_select);
   gfam_board u_board (.gpio_out, .gpio_oe, .far_level, .gpio_in);

   // ****************************************
   // bus tasks
   // ****************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = `GFAM_RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er = `GFAM_RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK("rdata", ed, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask
   function automatic logic [31:0] cw(input logic [2:0] m, s, input logic iv, lv);
      return {19'h0, lv, 3'h0, iv, 1'b0, s, 1'b0, m};
   endfunction
   task automatic pc(input int i, input logic [31:0] w);
      wr(12'(i * 4), w);
   endtask
   // pin logic is combinational, so the output flop needs one edge and sticky paths two; four leaves margin
   task automatic st;
      repeat (4) @(posedge aclk);
      #1;
   endtask
   task automatic test_done;
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      test_done;
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h000, 32'h0);
      rd(`GFAM_ADDR_BUF_CFG, 32'h0);
      rd(12'h100, 32'h0, `GFAM_RESP_SLVERR);
      wr(12'h100, 32'h1, `GFAM_RESP_SLVERR);
      wr(`GFAM_ADDR_INPUTS, 32'hffff);
      pc(0, cw(`GFAM_MODE_OUTPUT, 0, 0, 1));
      st;
      `CHK("oe0", 1'b0, gpio_oe[0])
      @(posedge aclk);
      init_done <= 1'b1;
      st;
      `CHK("out0", 2'b11, {gpio_oe[0], gpio_out[0]})
      rd(`GFAM_ADDR_INPUTS, {16'h0, far_level | 16'h0001});
      // two pins alike plus one inverted, alarm raised then dropped
      pc(1, cw(`GFAM_MODE_LOS, 3, 0, 0));
      pc(2, cw(`GFAM_MODE_LOS, 3, 0, 0));
      pc(3, cw(`GFAM_MODE_LOS, 3, 1, 0));
      for (int k = 1; k >= 0; k--) begin
         @(posedge aclk);
         ref_los_alarm <= 4'(k << 3);
         st;
         `CHK("los", {k == 0, k == 1, k == 1}, gpio_out[3:1])
      end
      pc(4, cw(`GFAM_MODE_LOL_LIVE, 4, 0, 0));
      @(posedge aclk);
      pll_locked <= 5'h0f;
      st;
      `CHK("lol", 1'b1, gpio_out[4])
      pc(5, cw(`GFAM_MODE_LOL_STICKY, 2, 0, 0));
      pc(6, cw(`GFAM_MODE_LOL_STICKY, 2, 1, 0));
      st;
      `CHK("stk idle", 2'b10, gpio_out[6:5])
      @(posedge aclk);
      pll_locked <= 5'h0b;
      st;
      `CHK("stk lose", 2'b01, gpio_out[6:5])
      rd(`GFAM_ADDR_STICKY, 32'h14);
      wr(`GFAM_ADDR_STICKY_CLR, 32'h4);
      st;
      `CHK("stk clr", 2'b10, gpio_out[6:5])
      @(posedge aclk);
      pll_locked <= 5'h0f;
      st;
      `CHK("stk gain", 2'b01, gpio_out[6:5])
      pc(7, cw(`GFAM_MODE_HO_LIVE, 1, 0, 0));
      pc(8, cw(`GFAM_MODE_HO_STICKY, 1, 0, 0));
      @(posedge aclk);
      pll_holdover <= 4'h2;
      st;
      `CHK("ho on", 2'b11, gpio_out[8:7])
      @(posedge aclk);
      pll_holdover <= 4'h0;
      st;
      `CHK("ho off", 2'b10, gpio_out[8:7])
      rd(`GFAM_ADDR_LIVE, 32'h0f0);
      wr(`GFAM_ADDR_STICKY_CLR, 32'hf1f);
      st;
      `CHK("ho clr", 1'b0, gpio_out[8])
      rd(`GFAM_ADDR_STICKY, 32'h0);
      // code 7 acts as input; an out-of-range loop select reads as no alarm
      pc(9, cw(3'h7, 0, 0, 1));
      pc(10, cw(`GFAM_MODE_LOL_LIVE, 7, 0, 0));
      st;
      `CHK("odd modes", 3'b100, {gpio_oe[10], gpio_out[10], gpio_oe[9]})
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 8; c++) begin
            inv = 1'(s ^ c);
            wr(`GFAM_ADDR_BUF_CFG, {26'h0, inv, 3'(c), 2'(s)});
            st;
            `CHK("buf", {2'(s), 3'(c)}, {diff_swing_select, crossing_level_select})
            // pads hold the level sampled before the source toggled at the last edge
            `CHK("tpad", ~buf_clk_src, true_output_pad)
            `CHK("cpad", ~buf_clk_src ^ inv, complement_output_pad)
         end
      end
      rd(`GFAM_ADDR_BUF_CFG, 32'h1f);
      for (int i = 0; i < 16; i++) pc(i, cw(`GFAM_MODE_OUTPUT, 0, 0, 1'(i)));
      st;
      `CHK("all out", 32'hffffaaaa, {gpio_oe, gpio_out})
      rd(12'h03c, cw(`GFAM_MODE_OUTPUT, 0, 0, 1));
      // mid-run reset returns every pin to input and the buffer codes to zero
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      `CHK("rst", 21'h0, {gpio_oe, diff_swing_select, crossing_level_select})
      rd(12'h03c, 32'h0);
      test_done;
   end
endmodule
`default_nettype wire
